//--- sacc_top.sv
// module: conversion control of a 10-bit successive-approximation converter, AXI4-Lite slave
//
// Behaviour
// - async enable set: converter clocked from dedicated async source, running only while converting
// - select and async enable both clear: source is quad bus clock
// - select set, async enable clear: source is the bus clock
// - selected source divided by 1, 2, 4 or 8 per two-bit field
// - async clock 1-2 MHz normally, 0.5-1 MHz in low-power configuration
// - async clock keeps running in stop mode so conversion proceeds
// - 10-bit result spans high and low registers; 8-bit rounded into low only
// - write to status/control starts conversion unless channel field is all ones
// - no hardware trigger input; only software or continuous mode start conversions
// - continuous mode restarts after every transfer until aborted
// - single mode powers converter down after the conversion
// - completion transfers result and sets flag; irq only if enable set then
// - 10-bit with high read, low unread: block transfer, flag clear, drop result
// - blocked transfer starts another conversion in single or continuous mode
// - abort on status write, clock config write, reset, stop without async clock
// - abort keeps last results; reset returns result registers to reset values
// - reset or abort enters idle low-power state at once, clocks off
// - 8-bit short: 18 converter clocks plus 3 bus clocks, follow-on 16
// - 8-bit long: 38 converter clocks plus 3 bus clocks, follow-on 36
// - 10-bit short: 21 converter clocks plus 3 bus clocks, follow-on 19
// - 10-bit long: 41 converter clocks plus 3 bus clocks, follow-on 39
// - completion flag sets on every successful conversion whatever the irq enable
//
// Our own choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module sacc_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [sacc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sacc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic stop_mode,
  input wire logic [sacc_pkg::RES_W-1:0] conv_data,
  output logic conv_power,
  output logic async_osc_run,
  output logic [sacc_pkg::CHAN_W-1:0] mux_channel,
  output logic completion_irq
);
  import sacc_pkg::*;

  // ----------------------------------------------------------------
  // bus slave: write address and data taken in either order
  // ----------------------------------------------------------------
  logic aw_have_q;
  logic w_have_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic do_wr;
  logic aw_take;
  logic w_take;
  logic rd_take;
  logic wr_map;

  assign aw_take = s_axi_awvalid && !aw_have_q;
  assign w_take = s_axi_wvalid && !w_have_q;
  assign do_wr = aw_have_q && w_have_q && !bvalid_q;
  assign rd_take = s_axi_arvalid && arready_q;
  assign wr_map = aw_addr_q == STATUS_CONTROL_REG_ADDR || aw_addr_q == CLOCK_CONFIG_REG_ADDR
                  || aw_addr_q == RESULT_HIGH_REG_ADDR || aw_addr_q == RESULT_LOW_REG_ADDR;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end else begin
        if (aw_take) begin
          aw_have_q <= 1'b1;
          aw_addr_q <= s_axi_awaddr;
        end
        if (w_take) begin
          w_have_q <= 1'b1;
          w_data_q <= s_axi_wdata;
          w_strb_q <= s_axi_wstrb;
        end
      end
    end
  end

  // ready is low while a word is held, so it comes straight from the holding flops
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else if (do_wr) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_map ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  logic [CHAN_W-1:0] chan_q;
  logic cont_q;
  logic ien_q;
  logic [CFG_W-1:0] cfg_q;
  logic wr_sc;
  logic wr_ck;
  logic [CHAN_W-1:0] new_chan;

  assign wr_sc = do_wr && aw_addr_q == STATUS_CONTROL_REG_ADDR && w_strb_q[0];
  assign wr_ck = do_wr && aw_addr_q == CLOCK_CONFIG_REG_ADDR && w_strb_q[0];
  assign new_chan = w_data_q[CHAN_LSB +: CHAN_W];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_q <= CHAN_RESET;
      cont_q <= 1'b0;
      ien_q <= 1'b0;
      cfg_q <= CFG_RESET;
    end else begin
      if (wr_sc) begin
        chan_q <= new_chan;
        cont_q <= w_data_q[CONT_BIT];
        ien_q <= w_data_q[IEN_BIT];
      end
      if (wr_ck) begin
        cfg_q <= w_data_q[CFG_W-1:0];
      end
    end
  end

  logic iclk;
  logic async_clock_enable;
  logic [1:0] div_sel;
  logic lsmp;
  logic lpc;
  logic mode8;
  assign iclk = cfg_q[ICLK_BIT];
  assign async_clock_enable = cfg_q[ASYNC_CLOCK_ENABLE_BIT];
  assign div_sel = cfg_q[DIV_LSB +: 2];
  assign lsmp = cfg_q[LSMP_BIT];
  assign lpc = cfg_q[LPC_BIT];
  assign mode8 = cfg_q[MODE8_BIT];

  // ----------------------------------------------------------------
  // converter clock: source ticks per bus cycle, divided by tick count
  // ----------------------------------------------------------------
  logic [8:0] async_cnt_q;
  logic async_tick;
  logic [2:0] step;
  logic [8:0] async_div;

  assign async_div = lpc ? 9'(ASYNC_DIV_LOWPWR) : 9'(ASYNC_DIV_NORMAL);
  assign async_tick = async_osc_run && async_cnt_q == async_div - 9'h001;

  // the dedicated oscillator only runs while a conversion holds it on; stop mode does not touch it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      async_cnt_q <= '0;
    end else if (!async_osc_run || async_tick) begin
      async_cnt_q <= '0;
    end else begin
      async_cnt_q <= async_cnt_q + 9'h001;
    end
  end

  always_comb begin
    if (async_clock_enable) begin
      step = async_tick ? 3'h1 : 3'h0;
    end else if (iclk) begin
      step = 3'h1;
    end else begin
      step = 3'(QUAD_TICKS);
    end
  end

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  sacc_state_e state_q;
  sacc_state_e state_d;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] converter_clock_first;
  logic [CNT_W-1:0] sync_len;
  logic hi_read_q;
  logic flag_q;
  logic flag_d;
  logic abort;
  logic conv_end;
  logic blocked;
  logic done_ok;
  logic rd_hi;
  logic rd_lo;

  always_comb begin
    case ({mode8, lsmp})
      2'b10: converter_clock_first = CNT_W'(CONVERTER_CLOCK_8_SHORT);
      2'b11: converter_clock_first = CNT_W'(CONVERTER_CLOCK_8_LONG);
      2'b00: converter_clock_first = CNT_W'(CONVERTER_CLOCK_10_SHORT);
      default: converter_clock_first = CNT_W'(CONVERTER_CLOCK_10_LONG);
    endcase
  end

  // async start-up time is paid before the first converter clock
  assign sync_len = async_clock_enable ? CNT_W'(SYNC_BUS_CLKS + ASYNC_START_CYC) : CNT_W'(SYNC_BUS_CLKS);
  assign abort = wr_ck || (stop_mode && !async_clock_enable);
  assign conv_end = state_q == SACC_CONV && step != 3'h0 && cnt_q <= CNT_W'(step);
  assign blocked = !mode8 && hi_read_q;
  assign done_ok = conv_end && !blocked && !wr_sc && !abort;

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    if (wr_sc) begin
      // rewriting the channel always drops the running conversion first
      state_d = (new_chan != CHAN_ALL_ONES) ? SACC_SYNC : SACC_IDLE;
      cnt_d = sync_len;
    end else if (abort) begin
      state_d = SACC_IDLE;
      cnt_d = '0;
    end else begin
      case (state_q)
        SACC_IDLE: begin
          cnt_d = '0;
        end
        SACC_SYNC: begin
          if (cnt_q <= CNT_W'(1)) begin
            state_d = SACC_CONV;
            cnt_d = converter_clock_first << div_sel;
          end else begin
            cnt_d = cnt_q - CNT_W'(1);
          end
        end
        SACC_CONV: begin
          if (conv_end) begin
            if (blocked) begin
              state_d = SACC_SYNC;
              cnt_d = sync_len;
            end else if (cont_q) begin
              cnt_d = (converter_clock_first - CNT_W'(CONVERTER_CLOCK_NEXT_SAVING)) << div_sel;
            end else begin
              state_d = SACC_IDLE;
              cnt_d = '0;
            end
          end else begin
            cnt_d = cnt_q - CNT_W'(step);
          end
        end
        default: begin
          state_d = SACC_IDLE;
          cnt_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= SACC_IDLE;
      cnt_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // results and completion flag
  // ----------------------------------------------------------------
  logic [RES_W-1:0] res_q;
  logic [8:0] rounded;

  assign rounded = 9'(conv_data[RES_W-1:2]) + 9'(conv_data[1]);
  assign rd_hi = rd_take && s_axi_araddr == RESULT_HIGH_REG_ADDR;
  assign rd_lo = rd_take && s_axi_araddr == RESULT_LOW_REG_ADDR;

  // aborts never touch the result; only reset clears it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      res_q <= RES_RESET;
    end else if (done_ok) begin
      if (mode8) begin
        res_q <= RES_W'(rounded[8] ? RES8_MAX : rounded[7:0]);
      end else begin
        res_q <= conv_data;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hi_read_q <= 1'b0;
    end else if (rd_hi) begin
      hi_read_q <= 1'b1;
    end else if (rd_lo) begin
      hi_read_q <= 1'b0;
    end
  end

  // a completion in the same cycle as a low-result read keeps the flag set; a status write in that cycle drops the completion
  always_comb begin
    flag_d = flag_q;
    if (wr_sc || rd_lo) begin
      flag_d = 1'b0;
    end
    if (done_ok) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= 1'b0;
      conv_power <= 1'b0;
      async_osc_run <= 1'b0;
      mux_channel <= CHAN_RESET;
      completion_irq <= 1'b0;
    end else begin
      flag_q <= flag_d;
      conv_power <= state_d != SACC_IDLE;
      async_osc_run <= state_d != SACC_IDLE && async_clock_enable;
      mux_channel <= wr_sc ? new_chan : chan_q;
      completion_irq <= flag_d && (wr_sc ? w_data_q[IEN_BIT] : ien_q);
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  logic [31:0] rd_word;
  logic [1:0] rd_resp;

  always_comb begin
    rd_word = '0;
    rd_resp = RESP_OKAY;
    case (s_axi_araddr)
      STATUS_CONTROL_REG_ADDR: begin
        rd_word[CHAN_LSB +: CHAN_W] = chan_q;
        rd_word[CONT_BIT] = cont_q;
        rd_word[IEN_BIT] = ien_q;
        rd_word[FLAG_BIT] = flag_q;
      end
      CLOCK_CONFIG_REG_ADDR: rd_word[CFG_W-1:0] = cfg_q;
      RESULT_HIGH_REG_ADDR: rd_word[1:0] = mode8 ? 2'h0 : res_q[RES_W-1:8];
      RESULT_LOW_REG_ADDR: rd_word[7:0] = res_q[7:0];
      default: rd_resp = RESP_SLVERR;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (rd_take) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_resp;
    end else if (rvalid_q && s_axi_rready) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

endmodule : sacc_top

//--- sacc_pkg.sv
// package: register map, field layout and timing constants of the converter control block
package sacc_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] STATUS_CONTROL_REG_ADDR = 8'h00;
  localparam logic [ADDR_W-1:0] CLOCK_CONFIG_REG_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] RESULT_HIGH_REG_ADDR = 8'h08;
  localparam logic [ADDR_W-1:0] RESULT_LOW_REG_ADDR = 8'h0C;

  // status_control_reg fields
  localparam int CHAN_LSB = 0;
  localparam int CHAN_W = 5;
  localparam int CONT_BIT = 5;
  localparam int IEN_BIT = 6;
  localparam int FLAG_BIT = 7;
  localparam logic [CHAN_W-1:0] CHAN_ALL_ONES = 5'h1F;
  localparam logic [CHAN_W-1:0] CHAN_RESET = 5'h1F;

  // clock_config_reg fields
  localparam int ICLK_BIT = 0;
  localparam int ASYNC_CLOCK_ENABLE_BIT = 1;
  localparam int DIV_LSB = 2;
  localparam int LSMP_BIT = 4;
  localparam int LPC_BIT = 5;
  localparam int MODE8_BIT = 6;
  localparam int CFG_W = 7;
  localparam logic [CFG_W-1:0] CFG_RESET = 7'h00;

  localparam int RES_W = 10;
  localparam logic [RES_W-1:0] RES_RESET = 10'h000;
  localparam logic [7:0] RES8_MAX = 8'hFF;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 200_000_000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int ASYNC_START_NS = 5000;
  localparam int ASYNC_START_CYC = (ASYNC_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ASYNC_HZ_NORMAL = 1_500_000;
  localparam int ASYNC_HZ_LOWPWR = 750_000;
  localparam int ASYNC_DIV_NORMAL = CLK_HZ / ASYNC_HZ_NORMAL;
  localparam int ASYNC_DIV_LOWPWR = CLK_HZ / ASYNC_HZ_LOWPWR;
  localparam int SYNC_BUS_CLKS = 3;
  localparam int QUAD_TICKS = 4;
  localparam int CNT_W = 11;

  // converter clocks of a first conversion, and how many fewer a follow-on takes
  localparam int CONVERTER_CLOCK_8_SHORT = 18;
  localparam int CONVERTER_CLOCK_8_LONG = 38;
  localparam int CONVERTER_CLOCK_10_SHORT = 21;
  localparam int CONVERTER_CLOCK_10_LONG = 41;
  localparam int CONVERTER_CLOCK_NEXT_SAVING = 2;

  typedef enum logic [3:0] {
    SACC_IDLE = 4'b0001,
    SACC_SYNC = 4'b0010,
    SACC_CONV = 4'b0100,
    SACC_SPARE = 4'b1000
  } sacc_state_e;

endpackage : sacc_pkg

//--- sacc_chk.sv
// checker: bus and conversion-control properties seen at the block ports
`timescale 1ns/1ps
module sacc_chk (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [sacc_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sacc_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic stop_mode,
  input wire logic [sacc_pkg::RES_W-1:0] conv_data,
  input wire logic conv_power,
  input wire logic async_osc_run,
  input wire logic [sacc_pkg::CHAN_W-1:0] mux_channel,
  input wire logic completion_irq
);
  import sacc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // two sampled cycles so a stop request has had one edge to abort
  sequence stop_plain;
    (stop_mode && !async_osc_run) [*2];
  endsequence
  chk_wr_answer: assert property (wr_taken |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not one cycle after execution");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before handshake");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before handshake");
  chk_high_width: assert property (
    rd_taken ##0 (s_axi_araddr == RESULT_HIGH_REG_ADDR) |=> s_axi_rvalid && s_axi_rdata[31:2] == 30'h0)
    else $error("high result wider than two bits");
  chk_low_width: assert property (
    rd_taken ##0 (s_axi_araddr == RESULT_LOW_REG_ADDR) |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("low result wider than eight bits");
  chk_idle_chan: assert property (mux_channel == CHAN_ALL_ONES && $stable(mux_channel) |-> !conv_power)
    else $error("converter powered with all-ones channel");
  chk_osc_conv: assert property (async_osc_run |-> conv_power || $past(conv_power))
    else $error("async clock running outside a conversion");
  chk_irq_cause: assert property ($rose(completion_irq) |-> $past(conv_power))
    else $error("interrupt raised without a completing conversion");
  chk_stop_abort: assert property (stop_plain |-> !conv_power)
    else $error("stop without async clock did not abort");
  chk_cfg_abort: assert property (
    wr_taken ##0 (s_axi_awaddr == CLOCK_CONFIG_REG_ADDR && s_axi_wstrb[0]) |-> ##3 !conv_power)
    else $error("clock config write did not abort");
endmodule : sacc_chk

bind sacc_top sacc_chk u_chk (.*);

//--- sacc_mux.sv
// partner model: input multiplexer and converter core feeding raw codes
`timescale 1ns/1ps
module sacc_mux (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic conv_power,
  input wire logic [sacc_pkg::CHAN_W-1:0] mux_channel,
  output logic [sacc_pkg::RES_W-1:0] conv_data
);
  import sacc_pkg::*;
  // unpowered core gives a toggling code so a stale sample never looks valid
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) conv_data <= 10'h000;
    else if (conv_power) conv_data <= {mux_channel, 5'h16};
    else conv_data <= ~conv_data;
  end
endmodule : sacc_mux

//--- sacc_top_tb.sv
// testbench: register-level tests of the converter control block
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp=%h got=%h", nm, e, a); end end
module sacc_top_tb;
  import sacc_pkg::*;
  logic clk = 1'h0, rst_b = 1'h0, stop_mode = 1'h0;
  logic [ADDR_W-1:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, conv_power, async_osc_run;
  logic completion_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, wr_resp;
  logic [RES_W-1:0] conv_data;
  logic [CHAN_W-1:0] mux_channel;
  int error_cnt = 0;
  int checked = 0;
  always #2.5 clk = ~clk;
  sacc_top dut (.*);
  sacc_mux u_mux (.*);

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    bit ta, tw;
    ta = 0;
    tw = 0;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!(ta && tw)) begin
      @(posedge clk);
      if (!ta && s_axi_awready) begin
        ta = 1;
        s_axi_awvalid <= 1'h0;
      end
      if (!tw && s_axi_wready) begin
        tw = 1;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    wr_resp = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask : wr

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'h0;
    `CHK("rdata", e, s_axi_rdata)
    `CHK("rresp", (a > 8'h0C) ? RESP_SLVERR : RESP_OKAY, s_axi_rresp)
  endtask : rc

  task automatic wait_done(output int n);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (conv_power && n < 9000);
  endtask : wait_done

  task automatic t_reset;
    rc(STATUS_CONTROL_REG_ADDR, 32'h1F);
    rc(CLOCK_CONFIG_REG_ADDR, 32'h0);
    rc(RESULT_HIGH_REG_ADDR, 32'h0);
    rc(RESULT_LOW_REG_ADDR, 32'h0);
    rc(8'h10, 32'h0);
    wr(8'h10, 32'h3);
    `CHK("unmapped_resp", RESP_SLVERR, wr_resp)
    wr(STATUS_CONTROL_REG_ADDR, 32'h3, 4'h0);
    repeat (3) @(posedge clk);
    `CHK("pwr_idle", 1'h0, conv_power)
    rc(STATUS_CONTROL_REG_ADDR, 32'h1F);
    $display("test reset done");
  endtask : t_reset

  task automatic t_modes;
    logic [6:0] cfg [10];
    logic [6:0] c;
    logic [4:0] ch;
    logic [9:0] dat;
    logic ien;
    int nk, p, t, ex, sl, n, r8;
    // rates chosen so the converter clock stays within its limits
    cfg = '{7'h41, 7'h51, 7'h01, 7'h11, 7'h0C, 7'h09, 7'h04, 7'h00, 7'h02, 7'h22};
    for (int i = 0; i < 10; i++) begin
      c = cfg[i];
      ch = 5'(i + 1);
      ien = i[0];
      dat = {ch, 5'h16};
      nk = c[MODE8_BIT] ? (c[LSMP_BIT] ? CONVERTER_CLOCK_8_LONG : CONVERTER_CLOCK_8_SHORT) : (c[LSMP_BIT] ? CONVERTER_CLOCK_10_LONG : CONVERTER_CLOCK_10_SHORT);
      p = !c[ASYNC_CLOCK_ENABLE_BIT] ? 1 : (c[LPC_BIT] ? ASYNC_DIV_LOWPWR : ASYNC_DIV_NORMAL);
      t = (c[ASYNC_CLOCK_ENABLE_BIT] || c[ICLK_BIT]) ? 1 : QUAD_TICKS;
      ex = SYNC_BUS_CLKS + (c[ASYNC_CLOCK_ENABLE_BIT] ? ASYNC_START_CYC : 0) + (nk * (1 << c[3:2]) * p + t - 1) / t;
      sl = 2 * p + 3;
      r8 = (int'(dat) >> 2) + int'(dat[1]);
      if (r8 > 255) r8 = 255;
      wr(CLOCK_CONFIG_REG_ADDR, 32'(c));
      wr(STATUS_CONTROL_REG_ADDR, {25'h0, ien, 1'h0, ch});
      `CHK("mux_chan", ch, mux_channel)
      if (c[ASYNC_CLOCK_ENABLE_BIT]) begin
        repeat (3) @(posedge clk);
        `CHK("osc_run", 1'h1, async_osc_run)
        stop_mode <= 1'h1;
      end
      wait_done(n);
      stop_mode <= 1'h0;
      `CHK("conv_time", 1'h1, n >= ex - sl && n <= ex + sl)
      `CHK("irq", ien, completion_irq)
      rc(STATUS_CONTROL_REG_ADDR, {24'h0, 1'h1, ien, 1'h0, ch});
      rc(RESULT_HIGH_REG_ADDR, c[MODE8_BIT] ? 32'h0 : 32'(dat[9:8]));
      rc(RESULT_LOW_REG_ADDR, c[MODE8_BIT] ? 32'(r8) : 32'(dat[7:0]));
      `CHK("pwr_off", 1'h0, conv_power)
    end
    $display("test modes done");
  endtask : t_modes

  task automatic t_block;
    int n;
    wr(CLOCK_CONFIG_REG_ADDR, 32'h01);
    wr(STATUS_CONTROL_REG_ADDR, 32'h14);
    wait_done(n);
    rc(RESULT_HIGH_REG_ADDR, 32'h2);
    // deliberately reads high after completion and leaves low unread to arm the block
    wr(STATUS_CONTROL_REG_ADDR, 32'h09);
    repeat (40) @(posedge clk);
    `CHK("pwr_retry", 1'h1, conv_power)
    rc(STATUS_CONTROL_REG_ADDR, 32'h09);
    rc(RESULT_LOW_REG_ADDR, 32'h96);
    wait_done(n);
    rc(RESULT_HIGH_REG_ADDR, 32'h1);
    rc(RESULT_LOW_REG_ADDR, 32'h36);
    $display("test block done");
  endtask : t_block

  task automatic t_abort;
    int n;
    wr(CLOCK_CONFIG_REG_ADDR, 32'h1D);
    wr(STATUS_CONTROL_REG_ADDR, 32'h07);
    repeat (10) @(posedge clk);
    `CHK("pwr_run", 1'h1, conv_power)
    wr(CLOCK_CONFIG_REG_ADDR, 32'h1D);
    @(posedge clk);
    `CHK("pwr_cfg_abort", 1'h0, conv_power)
    rc(RESULT_HIGH_REG_ADDR, 32'h1);
    rc(RESULT_LOW_REG_ADDR, 32'h36);
    wr(STATUS_CONTROL_REG_ADDR, 32'h07);
    repeat (10) @(posedge clk);
    stop_mode <= 1'h1;
    repeat (3) @(posedge clk);
    `CHK("pwr_stop_abort", 1'h0, conv_power)
    stop_mode <= 1'h0;
    rc(RESULT_LOW_REG_ADDR, 32'h36);
    wr(STATUS_CONTROL_REG_ADDR, 32'h07);
    wait_done(n);
    rc(RESULT_HIGH_REG_ADDR, 32'h0);
    rc(RESULT_LOW_REG_ADDR, 32'hF6);
    $display("test abort done");
  endtask : t_abort

  task automatic t_cont;
    wr(CLOCK_CONFIG_REG_ADDR, 32'h01);
    wr(STATUS_CONTROL_REG_ADDR, 32'h26);
    repeat (80) @(posedge clk);
    `CHK("pwr_cont", 1'h1, conv_power)
    rc(STATUS_CONTROL_REG_ADDR, 32'hA6);
    wr(STATUS_CONTROL_REG_ADDR, 32'h1F);
    repeat (2) @(posedge clk);
    `CHK("pwr_all_ones", 1'h0, conv_power)
    `CHK("mux_idle", CHAN_ALL_ONES, mux_channel)
    rc(RESULT_HIGH_REG_ADDR, 32'h0);
    rc(RESULT_LOW_REG_ADDR, 32'hD6);
    $display("test continuous done");
  endtask : t_cont

  task automatic t_rerst;
    rst_b <= 1'h0;
    repeat (3) @(posedge clk);
    `CHK("pwr_reset", 1'h0, conv_power)
    rst_b <= 1'h1;
    rc(RESULT_LOW_REG_ADDR, 32'h0);
    rc(STATUS_CONTROL_REG_ADDR, 32'h1F);
    $display("test mid reset done");
  endtask : t_rerst

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (3) @(posedge clk);
    rst_b <= 1'h1;
    t_reset();
    t_modes();
    t_block();
    t_abort();
    t_cont();
    t_rerst();
    summarize();
  end

  // the whole sequence needs about 12000 cycles
  initial begin
    repeat (80000) @(posedge clk);
    error_cnt++;
    summarize();
  end
endmodule : sacc_top_tb
